// ### include/cgd_map.svh
// timing counts, command codes and buffer and cursor limits for the display command decoder
// Overview of operation
// RQ1 - status read: cursor low seven, busy top
// RQ2 - clear blanks text, zeroes counter, increments
// RQ3 - home zeroes counter and shift offset
// RQ4 - entry bit1 picks increment or decrement
// RQ5 - entry bit0 shifts display with cursor
// RQ6 - shifting writes lengthen busy time
// RQ7 - control bit2 powers display, bit0 cursor
// RQ8 - enabled cursor lengthens every busy time; the code leaves it off in graphics mode and for the f0-f2 command bytes
// RQ9 - cursor and display move one place
// RQ10 - four-bit mode: upper lines, high nibble first
// RQ11 - eight-bit select restores full byte lines
// RQ12 - width select followed by brightness byte
// RQ13 - host waits before touching after width
// RQ14 - glyph address command loads glyph address
// RQ15 - display address command loads text address
// RQ16 - extended commands enter graphics, legacy leaves
// RQ17 - extended parameters sent with select high
// RQ18 - graphic cursor takes column then row
// RQ19 - area command takes box and action
// RQ20 - image data advances cursor inside area
// RQ21 - font command selects font or spacing
// RQ22 - characters drawn, spaced, cursor advanced
// RQ23 - busy from acceptance until time elapsed
`ifndef CGD_MAP_SVH
`define CGD_MAP_SVH
`define CGD_CLK_MHZ        100
`define CGD_T_STD_US       40
`define CGD_T_CTRL_US      50
`define CGD_T_CLEAR_US     150
`define CGD_T_HOME_US      500
`define CGD_T_SHIFT_US     150
`define CGD_T_CURSOR_US    20
`define CGD_T_AREA_US      500
`define CGD_T_GDATA_US     250
`define CGD_CYC(us)        ((us) * `CGD_CLK_MHZ)
`define CGD_TEXT_DEPTH     128
`define CGD_BLANK          8'h20
`define CGD_GX_MAX         8'd139
`define CGD_GY_MAX         8'd31
`define CGD_OP_FONT        8'hf2
`define CGD_OP_AREA        8'hf1
`define CGD_OP_GCUR        8'hf0
`endif

// ### include/cgd_pkg.sv
// types shared by both ends of the display command link
package cgd_pkg;
   typedef enum logic [2:0] {CGD_ACT_NONE, CGD_ACT_INV, CGD_ACT_FILL, CGD_ACT_CLR,
                             CGD_ACT_OUT, CGD_ACT_UNOUT, CGD_ACT_IMAGE} cgd_act_t;
   typedef enum {CGD_S_IDLE, CGD_S_CLEAR, CGD_S_PARAM, CGD_S_IMAGE, CGD_S_LUM} cgd_state_t;
   typedef enum {CGD_H_IDLE, CGD_H_WAIT, CGD_H_HI, CGD_H_LO, CGD_H_DONE} cgd_hstate_t;
endpackage

// ### include/cgd_if.sv
// parallel character-display bus between host and display
`timescale 1ns/10ps
interface cgd_if;
   logic       cmd_data_select;
   logic       rd_wr;
   logic       strobe;
   logic [7:0] host_data;
   logic       host_data_oe;
   logic [7:0] dev_data;
   logic       dev_data_oe;
   logic       busy;
   modport dev  (input cmd_data_select, rd_wr, strobe, host_data, host_data_oe,
                 output dev_data, dev_data_oe, busy);
   modport host (output cmd_data_select, rd_wr, strobe, host_data, host_data_oe,
                 input dev_data, dev_data_oe, busy);
endinterface

// ### core/cgd_busy_timer.sv
// busy countdown shared by the display end
`timescale 1ns/10ps
module cgd_busy_timer #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         load,
   input  wire logic [W-1:0] cycles,
   output logic              busy
);
   logic [W-1:0] cnt_r;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         cnt_r <= '0;
      else if (load)
         cnt_r <= cycles; // RQ23
      else if (cnt_r != '0)
         cnt_r <= cnt_r - W'(1);
   end
   assign busy = (cnt_r != '0);
endmodule

// ### core/cgd_dev.sv
// display end: decodes commands and data from the parallel bus
`include "cgd_map.svh"
`timescale 1ns/10ps
module cgd_dev #(
   parameter int DEPTH = `CGD_TEXT_DEPTH
) (
   input  wire logic clk,
   input  wire logic rst_b,
   cgd_if.dev        bus,
   output logic       display_on,
   output logic       cursor_on,
   output logic [1:0] brightness,
   output logic       graphics_mode,
   output logic [7:0] gfx_x,
   output logic [7:0] gfx_y,
   output logic [7:0] font_sel,
   output logic [1:0] char_spacing,
   output logic [2:0] area_action,
   output logic       pixel_wr,
   output logic [7:0] pixel_data,
   output logic [6:0] shift_offset
);
   localparam logic [15:0] C_STD   = 16'(`CGD_CYC(`CGD_T_STD_US));
   localparam logic [15:0] C_CTRL  = 16'(`CGD_CYC(`CGD_T_CTRL_US));
   localparam logic [15:0] C_CLEAR = 16'(`CGD_CYC(`CGD_T_CLEAR_US));
   localparam logic [15:0] C_HOME  = 16'(`CGD_CYC(`CGD_T_HOME_US));
   localparam logic [15:0] C_SHIFT = 16'(`CGD_CYC(`CGD_T_SHIFT_US));
   localparam logic [15:0] C_CUR   = 16'(`CGD_CYC(`CGD_T_CURSOR_US));
   localparam logic [15:0] C_AREA  = 16'(`CGD_CYC(`CGD_T_AREA_US));
   localparam logic [15:0] C_GDATA = 16'(`CGD_CYC(`CGD_T_GDATA_US));

   typedef struct packed {
      logic [2:0]  sel_s, rw_s, stb_s;
      logic [7:0]  d1, d2;
      cgd_pkg::cgd_state_t st;
      logic [6:0]  addr;
      logic        in_glyph;
      logic [5:0]  gaddr;
      logic        inc, shift_en, disp, cur, nib4, nib_hi;
      logic [3:0]  hi_nib;
      logic [1:0]  lum;
      logic        gfx;
      logic [7:0]  gx, gy, x1, y1, x2, y2, op, font;
      logic [1:0]  sp;
      logic [2:0]  pcnt;
      logic [2:0]  act;
      logic        pwr;
      logic [7:0]  pdat;
      logic [6:0]  soff;
      logic [7:0]  dout;
      logic        doe;
      logic        tload;
      logic [15:0] tcyc;
      logic [6:0]  clr_idx;
   } cgd_dev_t;

   cgd_dev_t   s_r, s_nxt;
   logic [7:0] text_buffer_ram [DEPTH];
   logic [7:0] glyph_ram [64];
   logic       busy_w;

   cgd_busy_timer #(.W(16)) u_timer (
      .clk   (clk),
      .rst_b (rst_b),
      .load  (s_r.tload),
      .cycles(s_r.tcyc),
      .busy  (busy_w)
   );

   // step the counter in the current direction
   function automatic logic [6:0] step(input logic [6:0] a, input logic up);
      step = up ? a + 7'd1 : a - 7'd1;
   endfunction

   // cursor adds its extra busy time to text-mode busy periods, not to the f0-f2 command bytes
   function automatic logic [15:0] dur(input logic [15:0] base, input logic cur);
      dur = cur ? base + C_CUR : base; // RQ8
   endfunction

   logic wr_ev, rd_ev, rd_end, sel;
   logic [7:0] byte_in;
   logic byte_ok;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.sel_s = {s_r.sel_s[1:0], bus.cmd_data_select};
      s_nxt.rw_s  = {s_r.rw_s[1:0], bus.rd_wr};
      s_nxt.stb_s = {s_r.stb_s[1:0], bus.strobe};
      s_nxt.d1    = bus.host_data;
      s_nxt.d2    = s_r.d1;
      s_nxt.tload = 1'b0;
      s_nxt.pwr   = 1'b0;
      sel   = s_r.sel_s[1];
      // falling strobe takes a write, high strobe drives a read
      wr_ev = s_r.stb_s[2] & ~s_r.stb_s[1] & ~s_r.rw_s[1];
      rd_ev = s_r.stb_s[1] & s_r.rw_s[1];
      rd_end = s_r.stb_s[2] & ~s_r.stb_s[1] & s_r.rw_s[1];
      byte_in = s_r.d2;
      byte_ok = 1'b0;
      if (wr_ev)
      begin
         if (s_r.nib4)
         begin
            // no busy between nibbles
            if (s_r.nib_hi) begin s_nxt.hi_nib = s_r.d2[7:4]; s_nxt.nib_hi = 1'b0; end // RQ10
            else
            begin
               byte_in = {s_r.hi_nib, s_r.d2[7:4]}; // RQ10
               byte_ok = 1'b1;
               s_nxt.nib_hi = 1'b1;
            end
         end
         else
            byte_ok = 1'b1; // RQ11
      end
      s_nxt.doe = rd_ev;
      // status busy bit also covers the power-up clear sweep
      if (rd_ev && !sel)
         s_nxt.dout = {bus.busy, s_r.addr}; // RQ1
      else if (rd_ev)
         s_nxt.dout = s_r.in_glyph ? glyph_ram[s_r.gaddr] : text_buffer_ram[s_r.addr];
      // a data read moves the counter like a write, but costs no busy time
      if (rd_end && sel && !s_r.gfx)
      begin
         if (!s_r.in_glyph) s_nxt.addr = step(s_r.addr, s_r.inc); // RQ4
         else s_nxt.gaddr = s_r.gaddr + 6'd1; // RQ14
         if (s_r.shift_en && !s_r.in_glyph) s_nxt.soff = step(s_r.soff, ~s_r.inc); // RQ5
      end
      case (s_r.st)
      cgd_pkg::CGD_S_CLEAR:
      begin
         s_nxt.clr_idx = s_r.clr_idx + 7'd1; // RQ2
         if (s_r.clr_idx == 7'(DEPTH - 1))
            s_nxt.st = cgd_pkg::CGD_S_IDLE;
      end
      default: ;
      endcase
      if (byte_ok && !sel)
      begin
         s_nxt.tload = 1'b1;
         s_nxt.tcyc  = dur(C_STD, s_r.cur && !s_r.gfx); // RQ23
         if (byte_in >= 8'hf0 && byte_in <= `CGD_OP_FONT)
         begin
            s_nxt.gfx = 1'b1; // RQ16
            s_nxt.op = byte_in;
            s_nxt.st = cgd_pkg::CGD_S_PARAM;
            s_nxt.pcnt = 3'd0;
            s_nxt.inc = 1'b1;
            s_nxt.tcyc = C_STD;
         end
         else
         begin
            s_nxt.gfx = 1'b0; // RQ16
            s_nxt.st = cgd_pkg::CGD_S_IDLE;
            if (byte_in == 8'h01)
            begin
               s_nxt.st = cgd_pkg::CGD_S_CLEAR; // RQ2
               s_nxt.clr_idx = 7'd0;
               s_nxt.addr = 7'd0;
               s_nxt.inc = 1'b1;
               s_nxt.soff = 7'd0;
               s_nxt.in_glyph = 1'b0;
               s_nxt.tcyc = dur(C_CLEAR, s_r.cur);
            end
            else if (byte_in[7:1] == 7'h01)
            begin
               s_nxt.addr = 7'd0; // RQ3
               s_nxt.soff = 7'd0;
               s_nxt.in_glyph = 1'b0;
               s_nxt.tcyc = dur(C_HOME, s_r.cur);
            end
            else if (byte_in[7:2] == 6'h01)
            begin
               s_nxt.inc = byte_in[1]; // RQ4
               s_nxt.shift_en = byte_in[0]; // RQ5
            end
            else if (byte_in[7:3] == 5'h01)
            begin
               s_nxt.disp = byte_in[2]; // RQ7
               s_nxt.cur = byte_in[0]; // RQ7
               s_nxt.tcyc = dur(C_CTRL, byte_in[0]);
            end
            else if (byte_in[7:4] == 4'h1)
            begin
               if (!byte_in[3]) s_nxt.addr = step(s_r.addr, byte_in[2]); // RQ9
               else
               begin
                  s_nxt.soff = step(s_r.soff, byte_in[2]); // RQ9
                  s_nxt.tcyc = dur(C_SHIFT, s_r.cur);
               end
            end
            else if (byte_in[7:5] == 3'h1)
            begin
               s_nxt.nib4 = ~byte_in[4]; // RQ10 RQ11
               s_nxt.nib_hi = 1'b1;
               s_nxt.st = cgd_pkg::CGD_S_LUM; // RQ12
            end
            else if (byte_in[7:6] == 2'h1)
            begin
               s_nxt.in_glyph = 1'b1; // RQ14
               s_nxt.gaddr = byte_in[5:0];
            end
            else if (byte_in[7])
            begin
               s_nxt.in_glyph = 1'b0; // RQ15
               s_nxt.addr = byte_in[6:0];
            end
         end
      end
      else if (byte_ok && sel)
      begin
         s_nxt.tload = 1'b1;
         // parameter bytes cost the standard time, a non-image area action byte standard plus area time, drawing data the graphics-data time
         s_nxt.tcyc = dur((s_r.gfx && s_r.st != cgd_pkg::CGD_S_PARAM) ? C_GDATA : C_STD,
                          s_r.cur && !s_r.gfx); // RQ23
         case (s_r.st)
         cgd_pkg::CGD_S_LUM:
         begin
            s_nxt.lum = byte_in[1:0]; // RQ12
            s_nxt.st = cgd_pkg::CGD_S_IDLE;
         end
         cgd_pkg::CGD_S_PARAM:
         begin
            s_nxt.pcnt = s_r.pcnt + 3'd1; // RQ17
            if (s_r.op == `CGD_OP_GCUR)
            begin
               if (s_r.pcnt == 3'd0) s_nxt.gx = (byte_in > `CGD_GX_MAX) ? `CGD_GX_MAX : byte_in; // RQ18
               else
               begin
                  s_nxt.gy = (byte_in > `CGD_GY_MAX) ? `CGD_GY_MAX : byte_in; // RQ18
                  s_nxt.st = cgd_pkg::CGD_S_IDLE;
               end
            end
            else if (s_r.op == `CGD_OP_FONT)
            begin
               if (byte_in == "1" || byte_in == "2") s_nxt.sp = byte_in[1:0]; // RQ21
               else s_nxt.font = byte_in; // RQ21
               s_nxt.st = cgd_pkg::CGD_S_IDLE;
            end
            else
            begin
               case (s_r.pcnt)
               3'd0: s_nxt.x1 = byte_in; // RQ19
               3'd1: s_nxt.y1 = byte_in;
               3'd2: s_nxt.x2 = byte_in;
               3'd3: s_nxt.y2 = byte_in;
               default:
               begin
                  s_nxt.st = cgd_pkg::CGD_S_IDLE;
                  s_nxt.tcyc = C_STD + C_AREA; // RQ19
                  s_nxt.act = cgd_pkg::CGD_ACT_NONE;
                  s_nxt.pwr = 1'b1;
                  case (byte_in)
                  "I", "l": s_nxt.act = cgd_pkg::CGD_ACT_INV;
                  "F": s_nxt.act = cgd_pkg::CGD_ACT_FILL;
                  "C": s_nxt.act = cgd_pkg::CGD_ACT_CLR;
                  "O": s_nxt.act = cgd_pkg::CGD_ACT_OUT;
                  "o": s_nxt.act = cgd_pkg::CGD_ACT_UNOUT;
                  "H", "V", "h", "v":
                  begin
                     s_nxt.act = cgd_pkg::CGD_ACT_IMAGE; // RQ20
                     s_nxt.st = cgd_pkg::CGD_S_IMAGE;
                     s_nxt.pwr = 1'b0;
                     s_nxt.gx = s_r.x1;
                     s_nxt.gy = s_r.y1;
                     s_nxt.tcyc = C_STD;
                  end
                  default: s_nxt.pwr = 1'b0;
                  endcase
                  s_nxt.op = byte_in;
               end
               endcase
            end
         end
         cgd_pkg::CGD_S_IMAGE:
         begin
            s_nxt.pwr = 1'b1; // RQ20
            s_nxt.pdat = byte_in;
            // lower-case actions move the cursor down, upper-case across
            if (s_r.op[5])
            begin
               if (s_r.gy >= s_r.y2) begin s_nxt.gy = s_r.y1; s_nxt.gx = s_r.gx + 8'd8; end
               else s_nxt.gy = s_r.gy + 8'd1;
            end
            else
            begin
               if (s_r.gx >= s_r.x2) begin s_nxt.gx = s_r.x1; s_nxt.gy = s_r.gy + 8'd8; end
               else s_nxt.gx = s_r.gx + 8'd1;
            end
         end
         default:
         begin
            if (s_r.gfx)
            begin
               s_nxt.pwr = 1'b1; // RQ22
               s_nxt.pdat = byte_in;
               // advance by a nominal glyph width plus spacing; wrap is host's job
               s_nxt.gx = s_r.gx + 8'd5 + {6'd0, s_r.sp}; // RQ22
            end
            else
            begin
               if (!s_r.in_glyph) s_nxt.addr = step(s_r.addr, s_r.inc); // RQ4
               else s_nxt.gaddr = s_r.gaddr + 6'd1; // RQ14
               if (s_r.shift_en && !s_r.in_glyph)
               begin
                  s_nxt.soff = step(s_r.soff, ~s_r.inc); // RQ5
                  s_nxt.tcyc = dur(C_STD + C_SHIFT, s_r.cur); // RQ6
               end
            end
         end
         endcase
      end
      if (!rst_b)
      begin
         s_nxt = '0;
         s_nxt.st = cgd_pkg::CGD_S_CLEAR;
         s_nxt.inc = 1'b1;
         s_nxt.disp = 1'b1;
         s_nxt.font = "L";
         s_nxt.sp = 2'd1;
         s_nxt.sel_s = 3'b111;
         s_nxt.rw_s = 3'b111;
      end
   end

   always_ff @(posedge clk)
   begin
      s_r <= s_nxt;
      if (s_r.st == cgd_pkg::CGD_S_CLEAR)
         text_buffer_ram[s_r.clr_idx] <= `CGD_BLANK; // RQ2
      else if (byte_ok && sel && !s_r.gfx && s_r.st == cgd_pkg::CGD_S_IDLE)
      begin
         if (s_r.in_glyph) glyph_ram[s_r.gaddr] <= byte_in; // RQ14
         else text_buffer_ram[s_r.addr] <= byte_in;
      end
   end

   assign bus.dev_data    = s_r.dout;
   assign bus.dev_data_oe = s_r.doe;
   assign bus.busy        = busy_w | (s_r.st == cgd_pkg::CGD_S_CLEAR);
   assign display_on      = s_r.disp;
   assign cursor_on       = s_r.cur & ~s_r.gfx; // RQ16
   assign brightness      = s_r.lum;
   assign graphics_mode   = s_r.gfx;
   assign gfx_x           = s_r.gx;
   assign gfx_y           = s_r.gy;
   assign font_sel        = s_r.font;
   assign char_spacing    = s_r.sp;
   assign area_action     = s_r.act;
   assign pixel_wr        = s_r.pwr;
   assign pixel_data      = s_r.pdat;
   assign shift_offset    = s_r.soff;
endmodule

// ### core/cgd_host.sv
// host end: sends one byte as command or data, waiting for busy to drop
`include "cgd_map.svh"
`timescale 1ns/10ps
module cgd_host #(
   parameter int HALF = 8
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   cgd_if.host             bus,
   input  wire logic       req,
   input  wire logic       req_cmd,
   input  wire logic [7:0] req_byte,
   input  wire logic       four_bit,
   output logic            ack
);
   typedef struct packed {
      cgd_pkg::cgd_hstate_t st;
      logic [1:0]  busy_s;
      logic [7:0]  cnt;
      logic [7:0]  b;
      logic        cmd, stb, ack, nib, oe;
      logic [7:0]  d;
   } cgd_host_t;
   cgd_host_t s_r, s_nxt;
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.busy_s = {s_r.busy_s[0], bus.busy};
      s_nxt.ack = 1'b0;
      case (s_r.st)
      cgd_pkg::CGD_H_IDLE:
         if (req)
         begin
            s_nxt.b = req_byte;
            s_nxt.cmd = req_cmd; // RQ17
            s_nxt.nib = four_bit;
            s_nxt.cnt = 8'(HALF); // RQ13
            s_nxt.st = cgd_pkg::CGD_H_WAIT;
         end
      cgd_pkg::CGD_H_WAIT:
         if (s_r.cnt != 8'd0) s_nxt.cnt = s_r.cnt - 8'd1;
         else if (!s_r.busy_s[1])
         begin
            s_nxt.st = cgd_pkg::CGD_H_HI;
            s_nxt.stb = 1'b1;
            s_nxt.oe = 1'b1;
            s_nxt.d = s_r.b; // RQ10
            s_nxt.cnt = 8'(HALF);
         end
      cgd_pkg::CGD_H_HI:
         if (s_r.cnt != 8'd0) s_nxt.cnt = s_r.cnt - 8'd1;
         else if (s_r.stb) begin s_nxt.stb = 1'b0; s_nxt.cnt = 8'(HALF); end
         else if (s_r.nib)
         begin
            s_nxt.nib = 1'b0;
            s_nxt.st = cgd_pkg::CGD_H_LO;
            s_nxt.d = {s_r.b[3:0], 4'h0}; // RQ10
            s_nxt.stb = 1'b1;
            s_nxt.cnt = 8'(HALF);
         end
         else s_nxt.st = cgd_pkg::CGD_H_DONE;
      cgd_pkg::CGD_H_LO:
         s_nxt.st = cgd_pkg::CGD_H_HI;
      default:
      begin
         s_nxt.oe = 1'b0;
         s_nxt.ack = 1'b1;
         s_nxt.st = cgd_pkg::CGD_H_IDLE;
      end
      endcase
      if (!rst_b)
      begin
         s_nxt = '0;
         s_nxt.cmd = 1'b1;
      end
   end
   always_ff @(posedge clk)
      s_r <= s_nxt;
   assign bus.cmd_data_select = ~s_r.cmd;
   assign bus.rd_wr           = 1'b0;
   assign bus.strobe          = s_r.stb;
   assign bus.host_data       = s_r.d;
   assign bus.host_data_oe    = s_r.oe;
   assign ack                 = s_r.ack;
endmodule

// ### bench/cgd_if_monitor.sv
// concurrent checks on the parallel bus between host end and display end
`timescale 1ns/10ps
module cgd_if_monitor (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       cmd_data_select,
   input wire logic       rd_wr,
   input wire logic       strobe,
   input wire logic [7:0] host_data,
   input wire logic       host_data_oe,
   input wire logic [7:0] dev_data,
   input wire logic       dev_data_oe,
   input wire logic       busy
);
   int unsigned len_r;
   logic [7:0]  since_fall_r;
   logic        wrote_r;
   // the busy after reset comes from the power-up clear, not a write
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         len_r        <= 0;
         since_fall_r <= 8'hff;
         wrote_r      <= 1'b0;
      end
      else
      begin
         len_r        <= busy ? len_r + 1 : 0;
         since_fall_r <= $fell(strobe) ? 8'h00 : since_fall_r + {7'h00, since_fall_r != 8'hff};
         wrote_r      <= wrote_r | ($fell(strobe) & ~rd_wr);
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_busy_soon;
      ##[1:60] busy;
   endsequence
   sequence s_hold;
      strobe[*4] ##[1:16] !strobe;
   endsequence
   a_busy_follows: assert property ($fell(strobe) && !rd_wr && !busy |-> s_busy_soon)
      else $error("busy did not follow an accepted write");
   a_busy_min: assert property ($fell(busy) && wrote_r |-> len_r >= 3990)
      else $error("busy period shorter than the standard time");
   a_busy_max: assert property (busy |-> len_r < 60000)
      else $error("busy period longer than any operation");
   a_busy_cause: assert property ($rose(busy) && wrote_r |-> since_fall_r <= 8'd8)
      else $error("busy rose without a write just before");
   a_waits_ready: assert property ($rose(strobe) |-> !$past(busy))
      else $error("strobe raised while device busy");
   a_strobe_width: assert property ($rose(strobe) |-> s_hold)
      else $error("strobe pulse width out of range");
   a_data_steady: assert property (strobe && $past(strobe) |-> $stable(host_data)
      && $stable(cmd_data_select) && $stable(rd_wr))
      else $error("bus lines changed while strobe high");
   a_host_drives: assert property (strobe && !rd_wr |-> host_data_oe)
      else $error("write strobe without host driving data");
   a_no_clash: assert property (host_data_oe |-> !dev_data_oe)
      else $error("both ends drive the data lines");
endmodule

// ### bench/tb_top.sv
// self-checking bench: host and display ends joined, plus a bench-driven display
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
   end
module tb_top;
   logic       clk;
   logic       rst_b;
   logic       req;
   logic       req_cmd;
   logic [7:0] req_byte;
   logic       four_bit;
   logic       ack;
   logic       display_on, cursor_on, graphics_mode;
   logic [1:0] brightness, char_spacing;
   logic [7:0] gfx_x, gfx_y, font_sel, nib_q;
   logic [6:0] shift_offset, side_shift;
   int         fail_count;
   int         comparisons;
   cgd_if bus_main ();
   cgd_if bus_side ();
   cgd_host #(.HALF(8)) cgd_host_inst (.clk(clk), .rst_b(rst_b), .bus(bus_main), .req(req),
      .req_cmd(req_cmd), .req_byte(req_byte), .four_bit(four_bit), .ack(ack));
   cgd_dev cgd_dev_inst (.clk(clk), .rst_b(rst_b), .bus(bus_main), .display_on(display_on),
      .cursor_on(cursor_on), .brightness(brightness), .graphics_mode(graphics_mode),
      .gfx_x(gfx_x), .gfx_y(gfx_y), .font_sel(font_sel), .char_spacing(char_spacing),
      .area_action(), .pixel_wr(), .pixel_data(), .shift_offset(shift_offset));
   // second display end driven straight from the bench for reads
   cgd_dev cgd_dev_side_inst (.clk(clk), .rst_b(rst_b), .bus(bus_side), .display_on(),
      .cursor_on(), .brightness(), .graphics_mode(), .gfx_x(), .gfx_y(), .font_sel(),
      .char_spacing(), .area_action(), .pixel_wr(), .pixel_data(), .shift_offset(side_shift));
   cgd_if_monitor cgd_if_monitor_inst (.clk(clk), .rst_b(rst_b),
      .cmd_data_select(bus_main.cmd_data_select), .rd_wr(bus_main.rd_wr),
      .strobe(bus_main.strobe), .host_data(bus_main.host_data),
      .host_data_oe(bus_main.host_data_oe), .dev_data(bus_main.dev_data),
      .dev_data_oe(bus_main.dev_data_oe), .busy(bus_main.busy));
   always #5 clk = ~clk;
   always @(negedge bus_main.strobe) nib_q = {nib_q[3:0], bus_main.host_data[7:4]};
   task automatic summarize;
      if (fail_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic count_busy(input bit side, output int n);
      int k;
      k = 0;
      n = 0;
      while ((side ? bus_side.busy : bus_main.busy) !== 1'b1 && k < 20)
      begin
         @(posedge clk);
         k++;
      end
      while ((side ? bus_side.busy : bus_main.busy) !== 1'b0 && n < 80000)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic send(input logic cmd, input logic [7:0] b, output int n);
      int k;
      @(posedge clk);
      req      <= 1'b1;
      req_cmd  <= cmd;
      req_byte <= b;
      @(posedge clk);
      req <= 1'b0;
      k = 0;
      while (ack !== 1'b1 && k < 80000)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 80000)
         fail_count++;
      count_busy(1'b0, n);
   endtask
   task automatic side_idle;
      int n;
      n = 0;
      while (bus_side.busy !== 1'b0 && n < 80000)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic sw(input logic rs, input logic [7:0] b);
      side_idle();
      @(posedge clk);
      bus_side.cmd_data_select <= rs;
      bus_side.rd_wr           <= 1'b0;
      bus_side.host_data       <= b;
      bus_side.host_data_oe    <= 1'b1;
      bus_side.strobe          <= 1'b1;
      repeat (4) @(posedge clk);
      bus_side.strobe <= 1'b0;
      repeat (6) @(posedge clk);
      // released lines must not keep the last value
      bus_side.host_data_oe <= 1'b0;
      bus_side.host_data    <= ~b;
   endtask
   task automatic sr(input logic rs, output logic [7:0] d);
      @(posedge clk);
      bus_side.cmd_data_select <= rs;
      bus_side.rd_wr           <= 1'b1;
      bus_side.strobe          <= 1'b1;
      repeat (6) @(posedge clk);
      d = bus_side.dev_data;
      bus_side.strobe <= 1'b0;
      @(posedge clk);
      bus_side.rd_wr <= 1'b0;
   endtask
   task automatic run_side;
      logic [7:0] d;
      int         n;
      sw(1'b0, 8'h85);
      sr(1'b0, d);
      `CHK(d, 8'h85)
      sw(1'b0, 8'h04);
      sw(1'b1, 8'h41);
      side_idle();
      sr(1'b0, d);
      `CHK(d, 8'h04)
      sw(1'b0, 8'h14);
      side_idle();
      sr(1'b0, d);
      `CHK(d, 8'h05)
      sw(1'b0, 8'h01);
      side_idle();
      sr(1'b0, d);
      `CHK(d, 8'h00)
      sw(1'b0, 8'h85);
      side_idle();
      sr(1'b1, d);
      `CHK(d, 8'h20)
      side_idle();
      sr(1'b0, d);
      `CHK(d, 8'h06)
      sw(1'b0, 8'h07);
      sw(1'b1, 8'h41);
      count_busy(1'b1, n);
      `CHK(n >= 18990 && n <= 19010, 1'b1)
      `CHK(side_shift != 7'h00, 1'b1)
      sw(1'b0, 8'h1c);
      side_idle();
      `CHK(side_shift, 7'h00)
      sw(1'b0, 8'h41);
      sw(1'b1, 8'h5a);
      sw(1'b0, 8'h41);
      side_idle();
      sr(1'b1, d);
      `CHK(d, 8'h5a)
   endtask
   task automatic run_main;
      int n;
      count_busy(1'b0, n);
      `CHK({display_on, brightness, graphics_mode, char_spacing}, 6'b1_00_0_01)
      `CHK(font_sel, 8'h4c)
      send(1'b1, 8'h0b, n);
      `CHK({display_on, cursor_on}, 2'b01)
      `CHK(n >= 6990 && n <= 7010, 1'b1)
      send(1'b1, 8'h0c, n);
      `CHK({display_on, cursor_on}, 2'b10)
      `CHK(n >= 4990 && n <= 5010, 1'b1)
      send(1'b1, 8'hf0, n);
      send(1'b0, 8'd10, n);
      send(1'b0, 8'd31, n);
      `CHK({graphics_mode, cursor_on, gfx_x, gfx_y}, {2'b10, 8'd10, 8'd31})
      send(1'b1, 8'hf2, n);
      send(1'b0, 8'h32, n);
      `CHK(char_spacing, 2'h2)
      send(1'b0, 8'h41, n);
      `CHK(gfx_x, 8'd17)
      `CHK(n >= 24990 && n <= 27010, 1'b1)
      send(1'b1, 8'h0d, n);
      `CHK({graphics_mode, cursor_on}, 2'b01)
      send(1'b1, 8'h20, n);
      // the brightness byte already arrives as two nibbles
      four_bit <= 1'b1;
      send(1'b0, 8'h02, n);
      `CHK(brightness, 2'h2)
      send(1'b1, 8'h0a, n);
      `CHK(nib_q, 8'h0a)
      `CHK(display_on, 1'b0)
      send(1'b1, 8'h30, n);
      four_bit <= 1'b0;
      send(1'b0, 8'h01, n);
      `CHK(brightness, 2'h1)
      send(1'b1, 8'h0c, n);
      `CHK(display_on, 1'b1)
   endtask
   initial
   begin
      repeat (100000) @(posedge clk);
      fail_count++;
      summarize();
   end
   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      req = 1'b0;
      req_cmd = 1'b0;
      req_byte = 8'h00;
      four_bit = 1'b0;
      fail_count = 0;
      comparisons = 0;
      bus_side.cmd_data_select = 1'b0;
      bus_side.rd_wr = 1'b0;
      bus_side.strobe = 1'b0;
      bus_side.host_data = 8'h00;
      bus_side.host_data_oe = 1'b0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      fork
         run_main();
         run_side();
      join
      summarize();
   end
endmodule
